// File: logic/mfi_pkg.sv
package mfi_pkg;

  // ---------------------------------------------------------------
  // flash window
  // ---------------------------------------------------------------
  localparam logic [31:0] MFI_FLASH_BASE   = 32'hff00_0000;
  localparam int          MFI_WIN_BITS     = 23;
  localparam int          MFI_FLASH_AW     = 21;

  // span end above the base, per capacity
  localparam logic [22:0] MFI_END_0M5      = 23'h07_ffff;
  localparam logic [22:0] MFI_END_1M       = 23'h0f_ffff;
  localparam logic [22:0] MFI_END_2M       = 23'h1f_ffff;
  localparam logic [22:0] MFI_END_3M       = 23'h2f_ffff;
  localparam logic [22:0] MFI_END_4M       = 23'h3f_ffff;
  localparam logic [22:0] MFI_END_6M       = 23'h5f_ffff;
  localparam logic [22:0] MFI_END_8M       = 23'h7f_ffff;

  // ---------------------------------------------------------------
  // capacity code, bits 2..0 of the identification code
  // ---------------------------------------------------------------
  localparam logic [2:0]  MFI_CAP_0M5      = 3'h5;
  localparam logic [2:0]  MFI_CAP_1M       = 3'h1;
  localparam logic [2:0]  MFI_CAP_2M       = 3'h2;
  localparam logic [2:0]  MFI_CAP_3M       = 3'h3;
  localparam logic [2:0]  MFI_CAP_4M       = 3'h4;
  localparam logic [2:0]  MFI_CAP_6M       = 3'h6;
  localparam logic [2:0]  MFI_CAP_8M       = 3'h0;
  localparam logic [2:0]  MFI_CAP_NONE     = 3'h7;

  // ---------------------------------------------------------------
  // wait states on the host bus
  // ---------------------------------------------------------------
  localparam int          MFI_RD_WAITS     = 3;
  localparam int          MFI_WR_WAITS     = 4;

  // ---------------------------------------------------------------
  // local registers
  // ---------------------------------------------------------------
  localparam logic [31:0] MFI_REG_BASE     = 32'hff80_1000;
  localparam logic [31:0] MFI_STATUS_OFS   = 32'h0000_0000;
  localparam logic [31:0] MFI_CTRL_OFS     = 32'h0000_0004;
  localparam int          MFI_ST_ID_LSB    = 0;
  localparam int          MFI_ST_PGMSW_BIT = 4;
  localparam int          MFI_ST_BLOCK_BIT = 5;
  localparam int          MFI_CT_SWPROT_BIT = 0;
  localparam int          MFI_CT_CLRBLK_BIT = 1;
  localparam logic        MFI_SWPROT_RST   = 1'b0;
  localparam logic [3:0]  MFI_ID_RST       = 4'hf;
  localparam logic [3:0]  MFI_FULL_STRB    = 4'hf;

  typedef enum logic [1:0] {
    MFI_IDLE,
    MFI_WAIT,
    MFI_DONE
  } mfi_state_e;

endpackage : mfi_pkg

// File: logic/mfi_flash_id.sv
`timescale 1ns/1ps
// How it works
// - four-bit id code; bit 3 low means coprocessor fitted
// - id bits 2..0 give flash capacity, 111 meaning no memory
// - id bit 3 follows the sense line, low when coprocessor fitted
// - flash window starts at the fixed base, at most 8 Mbyte
// - populated span end depends on the capacity code
// - flash data path toward the host is 32 bits
// - reads of any operand size are accepted
// - read cycles end after three wait states
// - write cycles end after four wait states
// - program enable off blocks program and erase writes
module mfi_flash_id #(
  parameter int RD_WAITS = mfi_pkg::MFI_RD_WAITS,
  parameter int WR_WAITS = mfi_pkg::MFI_WR_WAITS
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // module straps and switch
  input  wire logic        coproc_sense_n,
  input  wire logic [2:0]  capacity_code,
  input  wire logic        flash_program_enable_switch,
  // identification code to connector
  output logic      [3:0]  id_code,
  // flash array
  output logic      [mfi_pkg::MFI_FLASH_AW-1:0] flash_addr,
  output logic      [31:0] flash_wdata,
  input  wire logic [31:0] flash_rdata,
  output logic             flash_ce_n,
  output logic             flash_oe_n,
  output logic             flash_we_n
);
  import mfi_pkg::*;

  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  if (RD_WAITS < 1 || RD_WAITS > 15) begin : g_bad_rd
    $error("read wait states out of range");
  end
  if (WR_WAITS < 1 || WR_WAITS > 15) begin : g_bad_wr
    $error("write wait states out of range");
  end
  // the word address must cover the window exactly
  if (MFI_FLASH_AW != MFI_WIN_BITS - 2) begin : g_bad_aw
    $error("flash word address width does not match window");
  end

  localparam logic [3:0] RD_CNT = 4'(RD_WAITS);
  localparam logic [3:0] WR_CNT = 4'(WR_WAITS);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic logic [22:0] mfi_span_end(input logic [2:0] cap);
    case (cap)
      MFI_CAP_0M5: mfi_span_end = MFI_END_0M5;
      MFI_CAP_1M:  mfi_span_end = MFI_END_1M;
      MFI_CAP_2M:  mfi_span_end = MFI_END_2M;
      MFI_CAP_3M:  mfi_span_end = MFI_END_3M;
      MFI_CAP_4M:  mfi_span_end = MFI_END_4M;
      MFI_CAP_6M:  mfi_span_end = MFI_END_6M;
      MFI_CAP_8M:  mfi_span_end = MFI_END_8M;
      default:     mfi_span_end = '0;
    endcase
  endfunction : mfi_span_end

  mfi_state_e  state_q;
  logic [3:0]  wait_q;
  logic [3:0]  id_q;
  logic        swprot_q;
  logic        blocked_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [MFI_FLASH_AW-1:0] faddr_q;
  logic [31:0] fwdata_q;
  logic        ce_n_q;
  logic        oe_n_q;
  logic        we_n_q;

  logic setup;
  logic in_window;
  logic flash_hit;
  logic st_hit;
  logic ct_hit;
  logic full_word;
  logic wr_allowed;
  logic blk_event;
  logic blk_clear;
  logic flash_go;
  logic reg_go;
  logic last_wait;
  logic [31:0] reg_word;

  assign setup     = psel && !penable && (state_q == MFI_IDLE);
  assign in_window = paddr[31:MFI_WIN_BITS] ==
                     MFI_FLASH_BASE[31:MFI_WIN_BITS];
  assign flash_hit = in_window && (id_q[2:0] != MFI_CAP_NONE) &&
                     (paddr[22:0] <= mfi_span_end(id_q[2:0]));
  assign st_hit    = paddr == (MFI_REG_BASE + MFI_STATUS_OFS);
  assign ct_hit    = paddr == (MFI_REG_BASE + MFI_CTRL_OFS);
  // partial writes would corrupt the array; the host must not issue them
  assign full_word = (pstrb == MFI_FULL_STRB) &&
                     (paddr[1:0] == 2'b00);
  assign wr_allowed = flash_program_enable_switch && !swprot_q;
  assign blk_event = setup && flash_hit && pwrite && full_word &&
                     !wr_allowed;
  assign blk_clear = setup && ct_hit && pwrite &&
                     pwdata[MFI_CT_CLRBLK_BIT];
  // only legal flash cycles open the array; the rest answer at once
  assign flash_go  = setup && flash_hit && (!pwrite || full_word);
  assign reg_go    = setup && !flash_go;
  assign last_wait = (state_q == MFI_WAIT) && (wait_q == 4'h1);

  // ---------------------------------------------------------------
  // identification code
  // ---------------------------------------------------------------
  // straps are re-sampled every cycle, so a late-settling sense line
  // is picked up without a reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      id_q <= MFI_ID_RST;
    end else begin
      id_q <= {coproc_sense_n, capacity_code};
    end
  end

  // ---------------------------------------------------------------
  // local registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swprot_q <= MFI_SWPROT_RST;
    end else if (setup && ct_hit && pwrite) begin
      swprot_q <= pwdata[MFI_CT_SWPROT_BIT];
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blocked_q <= 1'b0;
    end else if (blk_event) begin
      blocked_q <= 1'b1;
    end else if (blk_clear) begin
      blocked_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // access sequencer
  // ---------------------------------------------------------------
  // a setup that arrives while a transfer is still open is ignored;
  // the bus protocol never produces one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= MFI_IDLE;
    end else begin
      case (state_q)
        MFI_IDLE: begin
          if (flash_go) begin
            state_q <= MFI_WAIT;
          end else if (reg_go) begin
            state_q <= MFI_DONE;
          end
        end
        MFI_WAIT: begin
          if (wait_q == 4'h1) begin
            state_q <= MFI_DONE;
          end
        end
        MFI_DONE: begin
          state_q <= MFI_IDLE;
        end
        default: begin
          state_q <= MFI_IDLE;
        end
      endcase
    end
  end

  // wait counter; wait states are fixed counts, not scaled to the clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= '0;
    end else if (flash_go) begin
      wait_q <= pwrite ? WR_CNT : RD_CNT;
    end else if (state_q == MFI_WAIT) begin
      wait_q <= wait_q - 4'h1;
    end
  end

  // registers and error answers come with no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= reg_go || last_wait;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= reg_go && !(st_hit || ct_hit);
    end
  end

  // register read word; zero for anything that is not a register access
  always_comb begin
    reg_word = '0;
    if (reg_go && st_hit) begin
      reg_word[MFI_ST_ID_LSB +: 4] = id_q;
      reg_word[MFI_ST_PGMSW_BIT]   = flash_program_enable_switch;
      reg_word[MFI_ST_BLOCK_BIT]   = blocked_q;
    end else if (reg_go && ct_hit) begin
      reg_word[MFI_CT_SWPROT_BIT]  = swprot_q;
    end
  end

  // any operand size reads the whole word; the master picks its lanes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (setup) begin
      prdata_q <= reg_word;
    end else if (last_wait) begin
      prdata_q <= flash_rdata;
    end
  end

  // ---------------------------------------------------------------
  // flash strobes
  // ---------------------------------------------------------------
  // strobes stand from the setup edge to the edge that ends the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ce_n_q <= 1'b1;
    end else if (flash_go) begin
      ce_n_q <= 1'b0;
    end else if (state_q == MFI_DONE) begin
      ce_n_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_n_q <= 1'b1;
    end else if (flash_go) begin
      oe_n_q <= pwrite;
    end else if (state_q == MFI_DONE) begin
      oe_n_q <= 1'b1;
    end
  end

  // blocked write still ends normally on the bus, so software that
  // ignores the switch does not hang; the sticky flag tells it later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      we_n_q <= 1'b1;
    end else if (flash_go) begin
      we_n_q <= !(pwrite && wr_allowed);
    end else if (state_q == MFI_DONE) begin
      we_n_q <= 1'b1;
    end
  end

  // address and data hold after the access so the array sees no glitch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      faddr_q <= '0;
    end else if (flash_go) begin
      faddr_q <= paddr[MFI_WIN_BITS-1:2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwdata_q <= '0;
    end else if (flash_go) begin
      fwdata_q <= pwdata;
    end
  end

  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign id_code     = id_q;
  assign flash_addr  = faddr_q;
  assign flash_wdata = fwdata_q;
  assign flash_ce_n  = ce_n_q;
  assign flash_oe_n  = oe_n_q;
  assign flash_we_n  = we_n_q;

endmodule : mfi_flash_id

// File: bench/mfi_flash_id_properties.sv
`timescale 1ns/1ps
module mfi_flash_id_properties #(
  parameter int RD_WAITS = 3,
  parameter int WR_WAITS = 4
) (
  // clock, reset and bus
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // straps and id
  input wire logic        coproc_sense_n,
  input wire logic [2:0]  capacity_code,
  input wire logic        flash_program_enable_switch,
  input wire logic [3:0]  id_code,
  // flash
  input wire logic [mfi_pkg::MFI_FLASH_AW-1:0] flash_addr,
  input wire logic [31:0] flash_rdata,
  input wire logic        flash_ce_n,
  input wire logic        flash_oe_n,
  input wire logic        flash_we_n
);
  import mfi_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_id;
    $past(presetn) |-> id_code == $past({coproc_sense_n, capacity_code});
  endproperty
  a_id: assert property (p_id)
    else $error("id code does not follow straps");
  property p_rd;
    $fell(flash_oe_n) |-> !pready [*3] ##1 pready;
  endproperty
  a_rd: assert property (p_rd)
    else $error("read wait states wrong");
  property p_wr;
    $fell(flash_we_n) |-> !pready [*4] ##1 pready;
  endproperty
  a_wr: assert property (p_wr)
    else $error("write wait states wrong");
  property p_we_sw;
    $fell(flash_we_n) |-> $past(flash_program_enable_switch);
  endproperty
  a_we_sw: assert property (p_we_sw)
    else $error("write strobe while protected");
  property p_win;
    $fell(flash_ce_n) |-> $past(paddr[31:23]) == 9'h1fe;
  endproperty
  a_win: assert property (p_win)
    else $error("flash selected outside window");
  property p_addr;
    !flash_ce_n |-> flash_addr == paddr[22:2];
  endproperty
  a_addr: assert property (p_addr)
    else $error("flash word address wrong");
  property p_rdata;
    pready && !flash_oe_n |-> prdata == $past(flash_rdata);
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("read data not the flash word");
  property p_err;
    pslverr |-> pready && flash_ce_n;
  endproperty
  a_err: assert property (p_err)
    else $error("error answer with flash strobe");
endmodule : mfi_flash_id_properties

bind mfi_flash_id mfi_flash_id_properties #(
  .RD_WAITS(RD_WAITS),
  .WR_WAITS(WR_WAITS)
) i_mfi_flash_id_properties (.*);

// File: bench/mfi_flash_model.sv
`timescale 1ns/1ps
module mfi_flash_model (
  // clock and flash pins
  input  wire logic        pclk,
  input  wire logic [mfi_pkg::MFI_FLASH_AW-1:0] flash_addr,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_oe_n,
  output logic      [31:0] flash_rdata
);
  import mfi_pkg::*;
  logic tgl_q = 1'h0;
  always_ff @(posedge pclk) tgl_q <= ~tgl_q;
  // released bus toggles so stale data never passes as valid
  always_comb begin
    if (!flash_ce_n && !flash_oe_n) flash_rdata = {11'h2d3, flash_addr};
    else flash_rdata = {32{tgl_q}};
  end
endmodule : mfi_flash_model

// File: bench/tb_mfi_flash_id.sv
`timescale 1ns/1ps
`define CHK(n, e, v) begin num_checks++; if ((v) !== (e)) begin \
  errors++; $display("MISMATCH %s exp %h got %h", n, e, v); end end
module tb_mfi_flash_id;
  import mfi_pkg::*;
  localparam logic [2:0]  CAPS [7] = '{MFI_CAP_0M5, MFI_CAP_1M,
    MFI_CAP_2M, MFI_CAP_3M, MFI_CAP_4M, MFI_CAP_6M, MFI_CAP_8M};
  localparam logic [22:0] ENDS [7] = '{MFI_END_0M5, MFI_END_1M,
    MFI_END_2M, MFI_END_3M, MFI_END_4M, MFI_END_6M, MFI_END_8M};
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic        pwrite = 1'h0, pready, pslverr, er, we_seen = 1'h0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd, flash_wdata;
  logic [31:0] flash_rdata;
  logic [3:0]  pstrb = 4'h0, id_code;
  logic [2:0]  capacity_code = 3'h7;
  logic        coproc_sense_n = 1'h1, flash_program_enable_switch = 1'h1;
  logic        flash_ce_n, flash_oe_n, flash_we_n;
  logic [MFI_FLASH_AW-1:0] flash_addr;
  int          errors = 0, num_checks = 0, wt;
  always #4 pclk = ~pclk;
  always @(negedge flash_we_n) we_seen = 1'h1;
  mfi_flash_id i_mfi_flash_id (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .coproc_sense_n,
    .capacity_code, .flash_program_enable_switch, .id_code, .flash_addr,
    .flash_wdata, .flash_rdata, .flash_ce_n, .flash_oe_n, .flash_we_n);
  mfi_flash_model i_mfi_flash_model (.pclk, .flash_addr, .flash_ce_n,
    .flash_oe_n, .flash_rdata);
  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic complete_run;
    if (errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  task automatic apb(input logic w, input logic [31:0] a, d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1 && n < 30) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 30) begin
      errors++;
      complete_run();
    end
    rd = prdata;
    er = pslverr;
    wt = n;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic fwr(input logic [31:0] a, input logic [3:0] s,
                     input logic e_er, e_we, input int e_wt);
    we_seen = 1'h0;
    apb(1'h1, MFI_FLASH_BASE + a, 32'hc3a5_0f96, s);
    `CHK("wr_err", e_er, er)
    `CHK("wr_strobe", e_we, we_seen)
    `CHK("wr_wait", e_wt, wt)
    `CHK("wr_data", 32'hc3a5_0f96, flash_wdata)
  endtask : fwr
  initial begin
    repeat (10) @(posedge pclk);
    `CHK("id_rst", MFI_ID_RST, id_code)
    presetn <= 1'h1;
    for (int i = 0; i < 16; i++) begin
      {coproc_sense_n, capacity_code} <= i[3:0];
      apb(1'h0, MFI_REG_BASE + MFI_STATUS_OFS, 32'h0, 4'h0);
      `CHK("id", i[3:0], id_code)
      `CHK("status_id", i[3:0], rd[3:0])
    end
    coproc_sense_n <= 1'h0;
    for (int k = 0; k < 7; k++) begin
      capacity_code <= CAPS[k];
      apb(1'h0, MFI_FLASH_BASE + ENDS[k] - 32'h3,
          32'h0, 4'h0);
      `CHK("rd_err", 1'h0, er)
      `CHK("rd_wait", 3, wt)
      `CHK("rd_data", {11'h2d3, ENDS[k][22:2]}, rd)
      apb(1'h0, MFI_FLASH_BASE + ENDS[k] + 32'h1,
          32'h0, 4'h0);
      `CHK("span_err", 1'h1, er)
      `CHK("err_wait", 0, wt)
    end
    capacity_code <= MFI_CAP_NONE;
    apb(1'h0, MFI_FLASH_BASE, 32'h0, 4'h0);
    `CHK("nomem_err", 1'h1, er)
    capacity_code <= MFI_CAP_8M;
    apb(1'h0, MFI_FLASH_BASE + 32'h1, 32'h0, 4'h0);
    `CHK("byte_err", 1'h0, er)
    `CHK("byte_data", {11'h2d3, 21'h0}, rd)
    fwr(32'h8, 4'hf, 1'h0, 1'h1, 4);
    fwr(32'h8, 4'h3, 1'h1, 1'h0, 0);
    fwr(32'ha, 4'hf, 1'h1, 1'h0, 0);
    flash_program_enable_switch <= 1'h0;
    fwr(32'h8, 4'hf, 1'h0, 1'h0, 4);
    apb(1'h0, MFI_REG_BASE + MFI_STATUS_OFS, 32'h0, 4'h0);
    `CHK("blocked", 1'h1, rd[MFI_ST_BLOCK_BIT])
    `CHK("sw_bit", 1'h0, rd[MFI_ST_PGMSW_BIT])
    flash_program_enable_switch <= 1'h1;
    apb(1'h1, MFI_REG_BASE + MFI_CTRL_OFS, 32'h3, 4'hf);
    apb(1'h0, MFI_REG_BASE + MFI_STATUS_OFS, 32'h0, 4'h0);
    `CHK("cleared", 1'h0, rd[MFI_ST_BLOCK_BIT])
    fwr(32'h8, 4'hf, 1'h0, 1'h0, 4);
    apb(1'h0, MFI_REG_BASE + MFI_CTRL_OFS, 32'h0, 4'h0);
    `CHK("ctrl", 2'h1, rd[1:0])
    apb(1'h0, 32'h0, 32'h0, 4'h0);
    `CHK("unmapped", 1'h1, er)
    complete_run();
  end
endmodule : tb_mfi_flash_id
